// *** egp_port.sv ***
// Eight-bit general-purpose I/O port with pad controls and input filters
//
// Notes on behaviour
// - A read of the data register returns the pin level for every pin set as input.
// - A read of the data register returns the latch for every pin set as output.
// - Every data register write loads all eight latch bits whatever the directions.
// - Each output pin is driven with the level held in its latch bit.
// - Reset clears the latch, makes every pin except bit 1 an input and turns every pull-up off.
// - Direction 0 disables the driver and reads the pin; 1 drives and reads the latch.
// - Bit 1 is an output-only pin and always reads its latch bit.
// - The direction bit of bit 1 is stored but does not change that pin.
// - The pull-up bit of bit 1 is stored but never turns on a pull-up there.
// - On an input pin a pull-up bit of 1 turns the pull-up on and 0 turns it off.
// - An output pin never has its pull-up on, whatever the pull-up bit says.
// - A slew bit of 1 enables slew-rate control on the pin and 0 disables it.
// - Slew bits have no effect on input pins.
// - A drive bit of 0 selects low drive and 1 selects high drive.
// - Each pin has an input low-pass filter, enabled from reset, that software can clear.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module egp_port #(
  parameter int unsigned FILTER_CYCLES = egp_pkg::FILTER_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire egp_pkg::egp_req_type req_i,
  output logic [7:0]                rdata_o,
  input  wire logic [7:0]           pin_i,
  output logic [7:0]                pin_o,
  output logic [7:0]                pin_oe_o,
  output egp_pkg::egp_pad_type      pad_o
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] latch_reg,  latch_next;
  logic [7:0] dir_reg,    dir_next;
  logic [7:0] pullup_reg, pullup_next;
  logic [7:0] slew_reg,   slew_next;
  logic [7:0] drive_reg,  drive_next;
  logic [7:0] filt_reg,   filt_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic [7:0] read_view;

  always_comb begin
    latch_next  = latch_reg;
    dir_next    = dir_reg;
    pullup_next = pullup_reg;
    slew_next   = slew_reg;
    drive_next  = drive_reg;
    filt_next   = filt_reg;
    if (req_i.wr) begin
      case (req_i.addr)
        egp_pkg::OFF_DATA_LATCH:     latch_next  = req_i.wdata;
        egp_pkg::OFF_DIRECTION:      dir_next    = req_i.wdata;
        egp_pkg::OFF_PULLUP_ENABLE:  pullup_next = req_i.wdata;
        egp_pkg::OFF_SLEW_CONTROL:   slew_next   = req_i.wdata;
        egp_pkg::OFF_DRIVE_STRENGTH: drive_next  = req_i.wdata;
        egp_pkg::OFF_FILTER_ENABLE:  filt_next   = req_i.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (req_i.rd) begin
      case (req_i.addr)
        egp_pkg::OFF_DATA_LATCH:     rdata_next = read_view;
        egp_pkg::OFF_DIRECTION:      rdata_next = dir_reg;
        egp_pkg::OFF_PULLUP_ENABLE:  rdata_next = pullup_reg;
        egp_pkg::OFF_SLEW_CONTROL:   rdata_next = slew_reg;
        egp_pkg::OFF_DRIVE_STRENGTH: rdata_next = drive_reg;
        egp_pkg::OFF_FILTER_ENABLE:  rdata_next = filt_reg;
        default:                     rdata_next = egp_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latch_reg  <= egp_pkg::RST_DATA_LATCH;
      dir_reg    <= egp_pkg::RST_DIRECTION;
      pullup_reg <= egp_pkg::RST_PULLUP_ENABLE;
      slew_reg   <= egp_pkg::RST_SLEW_CONTROL;
      drive_reg  <= egp_pkg::RST_DRIVE_STRENGTH;
      filt_reg   <= egp_pkg::RST_FILTER_ENABLE;
      rdata_reg  <= 8'h00;
    end else begin
      latch_reg  <= latch_next;
      dir_reg    <= dir_next;
      pullup_reg <= pullup_next;
      slew_reg   <= slew_next;
      drive_reg  <= drive_next;
      filt_reg   <= filt_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ------------------------------------------------------------
  // Input path: synchroniser then filter
  // ------------------------------------------------------------
  // The first stage is read only by the second, to keep metastability local
  logic [7:0] sync1_reg, sync2_reg;
  logic [7:0] filtered;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_filt
    egp_filter #(
      .CYCLES (FILTER_CYCLES)
    ) u_filt (
      .clk_i    (clk_i),
      .reset_i  (reset_i),
      .enable_i (filt_reg[i]),
      .level_i  (sync2_reg[i]),
      .level_o  (filtered[i])
    );
  end

  // ------------------------------------------------------------
  // Pin drive and pad controls
  // ------------------------------------------------------------
  logic [7:0] out_mask;

  // Bit 1 drives regardless of its stored direction
  assign out_mask = dir_reg | egp_pkg::OUTPUT_ONLY_MASK;
  assign read_view = (out_mask & latch_reg) | (~out_mask & filtered);
  assign pin_o     = latch_reg;
  assign pin_oe_o  = reset_i ? 8'h00 : out_mask;
  // The output-only bit is never an input, so its pull-up stays off
  assign pad_o.pullup_on  = reset_i ? 8'h00 : (pullup_reg & ~out_mask);
  assign pad_o.slew_on    = slew_reg & out_mask;
  assign pad_o.drive_high = drive_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [7:0] past_wdata;
  always_ff @(posedge clk_i) begin
    past_wdata <= req_i.wdata;
  end

  data_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_DATA_LATCH |=> pin_o == past_wdata)
    else $error("data write did not load all latch bits");

  input_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == egp_pkg::OFF_DATA_LATCH && filt_reg == 8'h00
    |=> ((rdata_o ^ $past(sync2_reg)) & ~$past(out_mask)) == 8'h00)
    else $error("input read did not return the pin level");

  output_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == egp_pkg::OFF_DATA_LATCH
    |=> ((rdata_o ^ $past(latch_reg)) & $past(out_mask)) == 8'h00)
    else $error("output read did not return the latch");

  only_bit_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == egp_pkg::OFF_DATA_LATCH
    |=> rdata_o[1] == $past(latch_reg[1]))
    else $error("output-only bit did not read its latch");

  drive_enable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_oe_o == (dir_reg | 8'h02))
    else $error("driver enable does not follow direction");

  only_pullup_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !pad_o.pullup_on[1])
    else $error("pull-up on at output-only pin");

  pullup_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pad_o.pullup_on & dir_reg) == 8'h00 && (pad_o.pullup_on | dir_reg | 8'h02)
    == (pullup_reg | dir_reg | 8'h02))
    else $error("pull-up does not follow enable and direction");

  slew_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pad_o.slew_on == (slew_reg & (dir_reg | 8'h02)))
    else $error("slew control active on input pin");

  reset_state_a: assert property (@(posedge clk_i)
    reset_i ##1 !reset_i |-> pin_o == 8'h00 && pin_oe_o == 8'h02 && pad_o.pullup_on == 8'h00)
    else $error("reset state wrong");

  reset_hold_a: assert property (@(posedge clk_i)
    reset_i |-> pin_oe_o == 8'h00 && pad_o.pullup_on == 8'h00)
    else $error("pin driven or pulled during reset");

  latch_reset_a: assert property (@(posedge clk_i)
    reset_i |=> latch_reg == 8'h00 && dir_reg == 8'h00 && pullup_reg == 8'h00)
    else $error("latch, direction or pull-up not cleared by reset");

  pad_reset_a: assert property (@(posedge clk_i)
    reset_i |=> slew_reg == 8'h00 && drive_reg == 8'h00)
    else $error("slew or drive not cleared by reset");

  rdata_reset_a: assert property (@(posedge clk_i)
    reset_i |=> rdata_o == 8'h00)
    else $error("read data not cleared by reset");

  dir_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_DIRECTION |=> dir_reg == past_wdata)
    else $error("direction write not stored");

  pullup_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_PULLUP_ENABLE |=> pullup_reg == past_wdata)
    else $error("pull-up write not stored");

  slew_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_SLEW_CONTROL |=> slew_reg == past_wdata)
    else $error("slew write not stored");

  drive_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_DRIVE_STRENGTH |=> pad_o.drive_high == past_wdata)
    else $error("drive write not applied");

  filter_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr == egp_pkg::OFF_FILTER_ENABLE |=> filt_reg == past_wdata)
    else $error("filter enable write not stored");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !req_i.wr |=> $stable(latch_reg))
    else $error("latch changed without a write");

  pin_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_o == latch_reg)
    else $error("pin drive differs from latch");

  only_bit_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_oe_o[1])
    else $error("output-only pin not driven");

  pullup_input_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pad_o.pullup_on & ~(dir_reg | egp_pkg::OUTPUT_ONLY_MASK))
    == (pullup_reg & ~(dir_reg | egp_pkg::OUTPUT_ONLY_MASK)))
    else $error("input pull-up does not follow its bit");

  slew_output_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pad_o.slew_on & (dir_reg | egp_pkg::OUTPUT_ONLY_MASK))
    == (slew_reg & (dir_reg | egp_pkg::OUTPUT_ONLY_MASK)))
    else $error("output slew does not follow its bit");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr > egp_pkg::OFF_FILTER_ENABLE |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  unmapped_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.wr && req_i.addr > egp_pkg::OFF_FILTER_ENABLE |=> $stable(dir_reg) && $stable(filt_reg))
    else $error("unmapped write changed a register");

  dir_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == egp_pkg::OFF_DIRECTION |=> rdata_o == $past(dir_reg))
    else $error("direction read wrong");

  filter_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd && req_i.addr == egp_pkg::OFF_FILTER_ENABLE |=> rdata_o == $past(filt_reg))
    else $error("filter enable read wrong");

  rdata_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");

  sync_chain_a: assert property (@(posedge clk_i) disable iff (reset_i)
    1'b1 |=> sync2_reg == $past(sync1_reg))
    else $error("second synchroniser stage skipped");

  filter_pass_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ((filtered ^ sync2_reg) & ~filt_reg) == 8'h00)
    else $error("disabled filter does not pass the level");

  filter_reset_a: assert property (@(posedge clk_i)
    reset_i |=> filt_reg == 8'hff)
    else $error("filters not enabled after reset");

endmodule

// *** egp_pkg.sv ***
// Package for the eight-bit GPIO port: register map, reset values, carriers
package egp_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register offsets (word index on the plain register port)
  localparam logic [2:0] OFF_DATA_LATCH     = 3'h0;
  localparam logic [2:0] OFF_DIRECTION      = 3'h1;
  localparam logic [2:0] OFF_PULLUP_ENABLE  = 3'h2;
  localparam logic [2:0] OFF_SLEW_CONTROL   = 3'h3;
  localparam logic [2:0] OFF_DRIVE_STRENGTH = 3'h4;
  localparam logic [2:0] OFF_FILTER_ENABLE  = 3'h5;

  // Reset values
  localparam logic [7:0] RST_DATA_LATCH     = 8'h00;
  localparam logic [7:0] RST_DIRECTION      = 8'h00;
  localparam logic [7:0] RST_PULLUP_ENABLE  = 8'h00;
  localparam logic [7:0] RST_SLEW_CONTROL   = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RST_FILTER_ENABLE  = 8'hff;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // Output-only pin position
  localparam int unsigned OUTPUT_ONLY_BIT = 1;
  localparam logic [7:0]  OUTPUT_ONLY_MASK = 8'h02;

  // Low-pass filter: samples that must agree before the filtered level moves
  localparam int unsigned FILTER_TIME_NS = 50;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } egp_req_type;

  // Per-pin analog controls towards the pad ring
  typedef struct packed {
    logic [7:0] pullup_on;
    logic [7:0] slew_on;
    logic [7:0] drive_high;
  } egp_pad_type;

endpackage

// *** egp_filter.sv ***
// Per-pin input low-pass filter: a level must be stable for a run of samples
`timescale 1ns/1ps
module egp_filter #(
  parameter int unsigned CYCLES = egp_pkg::FILTER_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic enable_i,
  input  wire logic level_i,
  output logic      level_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          out_reg;
  logic          out_next;

  always_comb begin
    count_next = count_reg;
    out_next   = out_reg;
    if (!enable_i || level_i == out_reg) begin
      count_next = '0;
      out_next   = enable_i ? out_reg : level_i;
    end else if (count_reg == CW'(CYCLES - 1)) begin
      count_next = '0;
      out_next   = level_i;
    end else begin
      count_next = count_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
      out_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  // A disabled filter is a plain wire, so reads follow the synchroniser with no extra lag
  assign level_o = enable_i ? out_reg : level_i;

endmodule

// *** egp_board.sv ***
// Board-side model of the eight pads: port drive, board drivers, pull-ups
`timescale 1ns/1ps
module egp_board (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] drv_val_i,
  input  wire logic [7:0] drv_en_i,
  output logic [7:0]      level_o
);
  // Undriven pads wander every cycle so a stale level is never trusted
  logic [7:0] float_reg = 8'h00;
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) level_o[i] = pin_o_i[i];
      else if (drv_en_i[i]) level_o[i] = drv_val_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_reg[i];
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the eight-bit GPIO port
`timescale 1ns/1ps
module tb_top;
  logic                 clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  egp_pkg::egp_req_type req = '0;
  egp_pkg::egp_pad_type pad;
  logic [7:0]           rdata, lvl, pin_o, pin_oe, d;
  logic [7:0]           drv_val = 8'h00;
  logic [7:0]           drv_en = 8'hfd;
  int                   fails = 0;
  int                   check_count = 0;
  // Short filter keeps the glitch scenario brief
  egp_port #(.FILTER_CYCLES(2)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req),
    .rdata_o(rdata), .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .pad_o(pad));
  egp_board u_board (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pullup_i(pad.pullup_on), .drv_val_i(drv_val), .drv_en_i(drv_en), .level_o(lvl));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rdchk(input string n, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] rst_view [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    @(posedge clk_i);
    #1 chk("oe", pin_oe, 8'h02);
    chk("pullup", pad.pullup_on, 8'h00);
    for (int a = 0; a < 8; a++) rdchk("reset view", a[2:0], rst_view[a]);
  endtask
  task automatic t_out();
    wr(egp_pkg::OFF_FILTER_ENABLE, 8'h00);
    drv_val <= 8'h3c;
    wr(egp_pkg::OFF_DATA_LATCH, 8'ha7);
    chk("pin_o", pin_o, 8'ha7);
    chk("oe", pin_oe, 8'h02);
    repeat (3) @(posedge clk_i);
    rdchk("input view", egp_pkg::OFF_DATA_LATCH, 8'h3e);
    drv_en <= 8'h0d;
    wr(egp_pkg::OFF_DIRECTION, 8'hf0);
    rdchk("dir", egp_pkg::OFF_DIRECTION, 8'hf0);
    chk("oe", pin_oe, 8'hf2);
    rdchk("output view", egp_pkg::OFF_DATA_LATCH, 8'hae);
  endtask
  task automatic t_pads();
    drv_en <= 8'h00;
    wr(egp_pkg::OFF_PULLUP_ENABLE, 8'hff);
    chk("pullup", pad.pullup_on, 8'h0d);
    repeat (3) @(posedge clk_i);
    rdchk("pulled view", egp_pkg::OFF_DATA_LATCH, 8'haf);
    wr(egp_pkg::OFF_PULLUP_ENABLE, 8'h08);
    chk("pullup", pad.pullup_on, 8'h08);
    wr(egp_pkg::OFF_SLEW_CONTROL, 8'hff);
    chk("slew", pad.slew_on, 8'hf2);
    wr(egp_pkg::OFF_SLEW_CONTROL, 8'h30);
    chk("slew", pad.slew_on, 8'h30);
    wr(egp_pkg::OFF_DRIVE_STRENGTH, 8'h5a);
    chk("drive", pad.drive_high, 8'h5a);
    wr(3'h6, 8'hff);
    rdchk("unmapped", 3'h6, 8'h00);
  endtask
  task automatic t_filter();
    drv_en <= 8'h01;
    drv_val <= 8'h00;
    wr(egp_pkg::OFF_FILTER_ENABLE, 8'h01);
    repeat (6) @(posedge clk_i);
    drv_val <= 8'h01;
    @(posedge clk_i);
    drv_val <= 8'h00;
    repeat (8) @(posedge clk_i);
    rd(egp_pkg::OFF_DATA_LATCH, d);
    chk("glitch", d & 8'h01, 8'h00);
    drv_val <= 8'h01;
    repeat (10) @(posedge clk_i);
    rd(egp_pkg::OFF_DATA_LATCH, d);
    chk("steady", d & 8'h01, 8'h01);
  endtask
  task automatic t_rerst();
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    #1 chk("oe in reset", pin_oe, 8'h00);
    chk("pullup in reset", pad.pullup_on, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("pin_o", pin_o, 8'h00);
    chk("oe", pin_oe, 8'h02);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run needs about a hundred cycles; this is a generous ceiling
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_out();
    t_pads();
    t_filter();
    t_rerst();
    summarize();
  end
endmodule
